// file: ext_bus_wait_ctrl.sv
// external bus dma write wait control, long wait and dram signal configuration
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
module ext_bus_wait_ctrl (
  input  wire logic                                    ref_clk_i,
  input  wire logic                                    srst_i,
  input  wire logic [ext_bus_wait_pkg::ADDR_W-1:0]     reg_addr_i,
  input  wire logic [ext_bus_wait_pkg::DATA_W-1:0]     reg_wdata_i,
  input  wire logic                                    reg_wr_i,
  input  wire logic                                    reg_rd_i,
  output logic      [ext_bus_wait_pkg::DATA_W-1:0]     reg_rdata_o,
  input  wire logic                                    dma_wr_start_i,
  input  wire logic [ext_bus_wait_pkg::AREA_W-1:0]     area_i,
  input  wire logic                                    mux_io_i,
  input  wire logic                                    bus16_i,
  input  wire logic                                    byte_hi_i,
  input  wire logic                                    byte_lo_i,
  input  wire logic                                    wait_n_i,
  output logic                                         cyc_busy_o,
  output logic                                         cyc_done_o,
  output logic                                         start_refused_o,
  output logic                                         wait_pin_pullup_o,
  output logic                                         ras_n_o,
  output logic                                         upper_col_strobe_n_o,
  output logic                                         lower_col_strobe_n_o,
  output logic                                         upper_write_strobe_n_o,
  output logic                                         lower_write_strobe_n_o
);
  import ext_bus_wait_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // state

  typedef enum logic {
    CYC_IDLE,
    CYC_RUN
  } cyc_phase_type;

  typedef struct packed {
    logic [7:0]        dma_write_wait_bits;
    logic [DATA_W-1:0] wait_pullup_longwait_ctrl;
    logic [DATA_W-1:0] dram_area_ctrl;
    logic              dram_space_enable;
    logic [DATA_W-1:0] rdata;
    cyc_phase_type     phase;
    logic              start;
    logic [CNT_W-1:0]  fixed_states;
    logic              sample_wait;
    logic              dram_cyc;
    logic              bus16;
    logic              byte_hi;
    logic              byte_lo;
    logic              refused;
  } ctrl_state_type;

  ctrl_state_type st_reg;
  ctrl_state_type st_next;

  bus_cfg_if cfg ();

  logic timer_busy;

  //////////////////////////////////////////////////////////////////////////////
  // area classification of the requested cycle

  logic             area_bit;
  logic             dram_hit;
  logic             mux_hit;
  logic             long_area;
  logic [1:0]       lw_code;
  logic [CNT_W-1:0] req_states;
  logic             req_sample;

  always_comb begin
    area_bit  = st_reg.dma_write_wait_bits[area_i];
    dram_hit  = (area_i == AREA_DRAM) && st_reg.dram_space_enable;
    mux_hit   = (area_i == AREA_MUX) && mux_io_i;
    long_area = (area_i == 3'h0) || (area_i == 3'h2) || (area_i == 3'h6);
    if (area_i == AREA_MUX) begin
      lw_code = st_reg.wait_pullup_longwait_ctrl[A6LW_MSB:A6LW_LSB];
    end else begin
      lw_code = st_reg.wait_pullup_longwait_ctrl[A02LW_MSB:A02LW_LSB];
    end
    // same table as the dma read cycles; only the control bit differs
    if (mux_hit) begin
      req_states = ST_MUX;
      req_sample = 1'b1;
    end else if (dram_hit) begin
      req_states = area_bit ? ST_LONG : ST_SHORT;
      req_sample = area_bit;
    end else if (long_area) begin
      // code 00 adds one state, so base plus code plus one
      req_states = ST_LW_BASE + {1'b0, lw_code} + ST_SHORT;
      req_sample = area_bit;
    end else begin
      req_states = area_bit ? ST_LONG : ST_SHORT;
      req_sample = area_bit;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers, read port and cycle launch

  always_comb begin
    st_next         = st_reg;
    st_next.rdata   = '0;
    st_next.start   = 1'b0;
    st_next.refused = 1'b0;

    if (reg_wr_i) begin
      if (reg_addr_i == OFS_DMA_WW) begin
        st_next.dma_write_wait_bits = reg_wdata_i[7:0];
      end else if (reg_addr_i == OFS_WAIT_LW) begin
        st_next.wait_pullup_longwait_ctrl = reg_wdata_i & MASK_WAIT_LW;
      end else if (reg_addr_i == OFS_DRAM_AREA) begin
        st_next.dram_area_ctrl = reg_wdata_i & MASK_DRAM_AREA;
      end else if (reg_addr_i == OFS_BUS_CTRL) begin
        st_next.dram_space_enable = reg_wdata_i[DRAM_SPACE_ENABLE_BIT];
      end
    end

    if (reg_rd_i) begin
      if (reg_addr_i == OFS_DMA_WW) begin
        st_next.rdata = {8'h00, st_reg.dma_write_wait_bits};
      end else if (reg_addr_i == OFS_WAIT_LW) begin
        st_next.rdata = st_reg.wait_pullup_longwait_ctrl & MASK_WAIT_LW;
      end else if (reg_addr_i == OFS_DRAM_AREA) begin
        st_next.rdata = st_reg.dram_area_ctrl;
      end else if (reg_addr_i == OFS_BUS_CTRL) begin
        st_next.rdata = {15'h0000, st_reg.dram_space_enable};
      end
    end

    case (st_reg.phase)
      CYC_IDLE: begin
        if (dma_wr_start_i) begin
          // a dram row cannot open while ras is still precharging
          if (cfg.precharge_busy) begin
            st_next.refused = 1'b1;
          end else begin
            st_next.start        = 1'b1;
            st_next.fixed_states = req_states;
            st_next.sample_wait  = req_sample;
            st_next.dram_cyc     = dram_hit;
            st_next.bus16        = bus16_i;
            st_next.byte_hi      = byte_hi_i;
            st_next.byte_lo      = byte_lo_i;
            st_next.phase        = CYC_RUN;
          end
        end
      end
      CYC_RUN: begin
        if (dma_wr_start_i) begin
          st_next.refused = 1'b1;
        end
        if (cfg.cyc_end) begin
          st_next.dram_cyc = 1'b0;
          st_next.phase    = CYC_IDLE;
        end
      end
      default: begin
        st_next.phase = CYC_IDLE;
      end
    endcase
  end

  // srst_i is the power-on reset; manual reset and standby never reach here
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st_reg                           <= '0;
      st_reg.dma_write_wait_bits       <= RST_DMA_WW;
      st_reg.wait_pullup_longwait_ctrl <= RST_WAIT_LW;
      st_reg.dram_area_ctrl            <= RST_DRAM_AREA;
      st_reg.dram_space_enable         <= RST_DRAM_EN;
      st_reg.phase                     <= CYC_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration towards the helpers; dram bits count only with dram enabled

  assign cfg.start              = st_reg.start;
  assign cfg.fixed_states       = st_reg.fixed_states;
  assign cfg.sample_wait        = st_reg.sample_wait;
  assign cfg.dram_cyc           = st_reg.dram_cyc;
  assign cfg.bus16              = st_reg.bus16;
  assign cfg.byte_hi            = st_reg.byte_hi;
  assign cfg.byte_lo            = st_reg.byte_lo;
  assign cfg.dram_space_enable  = st_reg.dram_space_enable;
  assign cfg.dual_cas_or_we_sel = st_reg.dram_space_enable
                                  && st_reg.dram_area_ctrl[CW2_BIT];
  assign cfg.ras_hold_low_idle  = st_reg.dram_space_enable
                                  && st_reg.dram_area_ctrl[RAS_HOLD_LOW_IDLE_BIT];
  assign cfg.precharge_len_sel  = st_reg.dram_space_enable
                                  && st_reg.dram_area_ctrl[TPC_BIT];

  cycle_timer u_timer (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .wait_n_i  (wait_n_i),
    .busy_o    (timer_busy),
    .cfg       (cfg.timer)
  );

  dram_strobe_gen u_dram (
    .ref_clk_i              (ref_clk_i),
    .srst_i                 (srst_i),
    .ras_n_o                (ras_n_o),
    .upper_col_strobe_n_o   (upper_col_strobe_n_o),
    .lower_col_strobe_n_o   (lower_col_strobe_n_o),
    .upper_write_strobe_n_o (upper_write_strobe_n_o),
    .lower_write_strobe_n_o (lower_write_strobe_n_o),
    .cfg                    (cfg.dram)
  );

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata_o       = st_reg.rdata;
  assign cyc_busy_o        = timer_busy;
  assign cyc_done_o        = cfg.cyc_end;
  assign start_refused_o   = st_reg.refused;
  assign wait_pin_pullup_o = st_reg.wait_pullup_longwait_ctrl[WPU_BIT];
endmodule // ext_bus_wait_ctrl

// file: ext_bus_wait_pkg.sv
// constants for the external bus wait and dram configuration block
package ext_bus_wait_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int CNT_W  = 3;
  localparam int AREA_W = 3;
  //////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [ADDR_W-1:0] OFS_DMA_WW    = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_WAIT_LW   = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_DRAM_AREA = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_BUS_CTRL  = 4'hc;
  //////////////////////////////////////////////////////////////////////////////
  // reset values and writable masks
  localparam logic [7:0]        RST_DMA_WW     = 8'hff;
  localparam logic [DATA_W-1:0] RST_WAIT_LW    = 16'hf800;
  localparam logic [DATA_W-1:0] RST_DRAM_AREA  = 16'h0000;
  localparam logic              RST_DRAM_EN    = 1'b0;
  localparam logic [DATA_W-1:0] MASK_WAIT_LW   = 16'hf800;
  localparam logic [DATA_W-1:0] MASK_DRAM_AREA = 16'hff00;
  //////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int WPU_BIT    = 15;
  localparam int A02LW_MSB  = 14;
  localparam int A02LW_LSB  = 13;
  localparam int A6LW_MSB   = 12;
  localparam int A6LW_LSB   = 11;
  localparam int CW2_BIT    = 15;
  localparam int RAS_HOLD_LOW_IDLE_BIT   = 14;
  localparam int TPC_BIT    = 13;
  localparam int DRAM_SPACE_ENABLE_BIT  = 0;
  //////////////////////////////////////////////////////////////////////////////
  // state counts and area codes
  localparam logic [CNT_W-1:0] ST_SHORT   = 3'h1;
  localparam logic [CNT_W-1:0] ST_LONG    = 3'h2;
  localparam logic [CNT_W-1:0] ST_LW_BASE = 3'h1;
  localparam logic [CNT_W-1:0] ST_MUX     = 3'h4;
  localparam logic [1:0]       PRE_SHORT  = 2'h1;
  localparam logic [1:0]       PRE_LONG   = 2'h2;
  localparam logic [AREA_W-1:0] AREA_DRAM = 3'h1;
  localparam logic [AREA_W-1:0] AREA_MUX  = 3'h6;
endpackage

// file: bus_cfg_if.sv
// configuration and cycle handshake shared by the controller and its helpers
`timescale 1ns/1ps
interface bus_cfg_if;
  logic                         start;
  logic [ext_bus_wait_pkg::CNT_W-1:0] fixed_states;
  logic                         sample_wait;
  logic                         dram_cyc;
  logic                         cyc_end;
  logic                         precharge_busy;
  logic                         bus16;
  logic                         byte_hi;
  logic                         byte_lo;
  logic                         dual_cas_or_we_sel;
  logic                         ras_hold_low_idle;
  logic                         precharge_len_sel;
  logic                         dram_space_enable;
  modport ctrl  (output start, fixed_states, sample_wait, dram_cyc, bus16, byte_hi,
                 byte_lo, dual_cas_or_we_sel, ras_hold_low_idle, precharge_len_sel,
                 dram_space_enable, input cyc_end, precharge_busy);
  modport timer (input start, fixed_states, sample_wait, output cyc_end);
  modport dram  (input dram_cyc, cyc_end, bus16, byte_hi, byte_lo, dual_cas_or_we_sel,
                 ras_hold_low_idle, precharge_len_sel, dram_space_enable,
                 output precharge_busy);
endinterface // bus_cfg_if

// file: cycle_timer.sv
// counts the fixed states of a dma write cycle and stretches it on wait
`timescale 1ns/1ps
module cycle_timer (
  input  wire logic   ref_clk_i,
  input  wire logic   srst_i,
  input  wire logic   wait_n_i,
  output logic        busy_o,
  bus_cfg_if.timer    cfg
);
  import ext_bus_wait_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             run;
    logic             sample;
    logic             done;
  } timer_state_type;

  timer_state_type st_reg;
  timer_state_type st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    if (cfg.start) begin
      st_next.cnt    = cfg.fixed_states;
      st_next.run    = 1'b1;
      st_next.sample = cfg.sample_wait;
    end else if (st_reg.run) begin
      if (st_reg.cnt > ST_SHORT) begin
        st_next.cnt = st_reg.cnt - ST_SHORT;
      end else if (!(st_reg.sample && !wait_n_i)) begin
        st_next.run  = 1'b0;
        st_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cfg.cyc_end = st_reg.done;
  assign busy_o      = st_reg.run;
endmodule // cycle_timer

// file: dram_strobe_gen.sv
// drives ras, cas and write strobes of a dram cycle and times the precharge
`timescale 1ns/1ps
module dram_strobe_gen (
  input  wire logic ref_clk_i,
  input  wire logic srst_i,
  output logic      ras_n_o,
  output logic      upper_col_strobe_n_o,
  output logic      lower_col_strobe_n_o,
  output logic      upper_write_strobe_n_o,
  output logic      lower_write_strobe_n_o,
  bus_cfg_if.dram   cfg
);
  import ext_bus_wait_pkg::*;

  typedef struct packed {
    logic       ras_n;
    logic       cas_hi_n;
    logic       cas_lo_n;
    logic       wr_hi_n;
    logic       wr_lo_n;
    logic [1:0] pre_cnt;
  } dram_state_type;

  dram_state_type st_reg;
  dram_state_type st_next;

  always_comb begin
    st_next          = st_reg;
    st_next.cas_hi_n = 1'b1;
    st_next.cas_lo_n = 1'b1;
    st_next.wr_hi_n  = 1'b1;
    st_next.wr_lo_n  = 1'b1;
    if (st_reg.pre_cnt != 2'h0) begin
      st_next.pre_cnt = st_reg.pre_cnt - 2'h1;
    end
    if (cfg.dram_cyc && !cfg.cyc_end) begin
      st_next.ras_n = 1'b0;
      if (!cfg.bus16) begin
        st_next.cas_lo_n = 1'b0;
        st_next.wr_lo_n  = 1'b0;
      end else if (!cfg.dual_cas_or_we_sel) begin
        st_next.cas_hi_n = !cfg.byte_hi;
        st_next.cas_lo_n = !cfg.byte_lo;
        st_next.wr_lo_n  = 1'b0;
      end else begin
        st_next.cas_lo_n = 1'b0;
        st_next.wr_hi_n  = !cfg.byte_hi;
        st_next.wr_lo_n  = !cfg.byte_lo;
      end
    end else if (!st_reg.ras_n && (!cfg.ras_hold_low_idle || !cfg.dram_space_enable)) begin
      // ras rising starts the precharge, so the next row open must wait for it
      st_next.ras_n   = 1'b1;
      st_next.pre_cnt = cfg.precharge_len_sel ? PRE_LONG : PRE_SHORT;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st_reg <= '{ras_n: 1'b1, cas_hi_n: 1'b1, cas_lo_n: 1'b1, wr_hi_n: 1'b1,
                  wr_lo_n: 1'b1, pre_cnt: 2'h0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign cfg.precharge_busy        = (st_reg.pre_cnt != 2'h0);
  assign ras_n_o                   = st_reg.ras_n;
  assign upper_col_strobe_n_o      = st_reg.cas_hi_n;
  assign lower_col_strobe_n_o      = st_reg.cas_lo_n;
  assign upper_write_strobe_n_o    = st_reg.wr_hi_n;
  assign lower_write_strobe_n_o    = st_reg.wr_lo_n;
endmodule // dram_strobe_gen

// file: ext_mem_model.sv
// external memory model that holds wait low for the extra states it needs
`timescale 1ns/1ps
module ext_mem_model (
  input  wire logic       ref_clk_i,
  input  wire logic       busy_i,
  input  wire logic [3:0] start_at_i,
  input  wire logic [3:0] extra_i,
  output logic            wait_n_o
);
  logic [3:0] state_cnt_reg = 4'h0;
  always_ff @(posedge ref_clk_i) begin
    state_cnt_reg <= (busy_i === 1'b1) ? state_cnt_reg + 4'h1 : 4'h0;
  end
  // outside a cycle the pull-up wins, so the pin never floats to a stale level
  assign wait_n_o = !(busy_i === 1'b1 && state_cnt_reg >= start_at_i
                      && state_cnt_reg < start_at_i + extra_i);
endmodule // ext_mem_model

// file: ext_bus_wait_props.sv
// concurrent checks on the ports of the dma write wait and dram block
`timescale 1ns/1ps
module ext_bus_wait_props (
  input wire logic                                ref_clk_i,
  input wire logic                                srst_i,
  input wire logic [ext_bus_wait_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [ext_bus_wait_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic                                reg_wr_i,
  input wire logic                                reg_rd_i,
  input wire logic [ext_bus_wait_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic                                dma_wr_start_i,
  input wire logic                                bus16_i,
  input wire logic                                cyc_busy_o,
  input wire logic                                cyc_done_o,
  input wire logic                                start_refused_o,
  input wire logic                                wait_pin_pullup_o,
  input wire logic                                upper_col_strobe_n_o,
  input wire logic                                lower_col_strobe_n_o,
  input wire logic                                upper_write_strobe_n_o
);
  import ext_bus_wait_pkg::*;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);
  //////////////////////////////////////////////////////////////////////////////
  sequence s_wr_wait_reg;
    reg_wr_i && reg_addr_i == OFS_WAIT_LW ##1 !reg_wr_i;
  endsequence
  sequence s_rd_wait_reg;
    reg_rd_i && reg_addr_i == OFS_WAIT_LW;
  endsequence
  sequence s_cyc_end;
    !cyc_busy_o && cyc_done_o;
  endsequence
  // two cycles allow for an output stage behind the register
  property p_pullup;
    s_wr_wait_reg |-> ##1 wait_pin_pullup_o == $past(reg_wdata_i[WPU_BIT], 2);
  endproperty
  property p_rd_idle;
    !reg_rd_i |=> reg_rdata_o == 16'h0000;
  endproperty
  property p_wait_rsvd;
    s_rd_wait_reg |=> reg_rdata_o[10:0] == 11'h000;
  endproperty
  property p_done_end;
    $fell(cyc_busy_o) |-> s_cyc_end;
  endproperty
  property p_done_pulse;
    cyc_done_o |=> !cyc_done_o;
  endproperty
  property p_busy_cause;
    $rose(cyc_busy_o) |-> $past(dma_wr_start_i, 2);
  endproperty
  property p_busy_bound;
    $rose(cyc_busy_o) |-> ##[1:32] s_cyc_end;
  endproperty
  property p_refuse;
    dma_wr_start_i && cyc_busy_o |=> start_refused_o;
  endproperty
  property p_narrow;
    !bus16_i |-> upper_col_strobe_n_o && upper_write_strobe_n_o;
  endproperty
  property p_cas_in_cyc;
    !lower_col_strobe_n_o |-> cyc_busy_o || $past(cyc_busy_o);
  endproperty
  //////////////////////////////////////////////////////////////////////////////
  a_pullup: assert property (p_pullup) else $error("pull-up level wrong");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  a_wait_rsvd: assert property (p_wait_rsvd) else $error("reserved bits set");
  a_done_end: assert property (p_done_end) else $error("no done at end");
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  a_busy_cause: assert property (p_busy_cause) else $error("busy without start");
  a_busy_bound: assert property (p_busy_bound) else $error("cycle too long");
  a_refuse: assert property (p_refuse) else $error("busy start taken");
  a_narrow: assert property (p_narrow) else $error("upper strobe in 8-bit");
  a_cas_in_cyc: assert property (p_cas_in_cyc) else $error("cas outside cycle");
endmodule // ext_bus_wait_props

bind ext_bus_wait_ctrl ext_bus_wait_props i_props (
  .ref_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .dma_wr_start_i, .bus16_i, .cyc_busy_o, .cyc_done_o, .start_refused_o,
  .wait_pin_pullup_o, .upper_col_strobe_n_o, .lower_col_strobe_n_o, .upper_write_strobe_n_o
);

// file: test_ext_bus_wait_ctrl.sv
// self-checking testbench for the dma write wait and dram configuration block
`timescale 1ns/1ps
module test_ext_bus_wait_ctrl;
  import ext_bus_wait_pkg::*;
  logic              ref_clk_i = 1'b0;
  logic              srst_i = 1'b1;
  logic [ADDR_W-1:0] reg_addr_i = 4'h0;
  logic [DATA_W-1:0] reg_wdata_i = 16'h0000;
  logic [DATA_W-1:0] reg_rdata_o;
  logic [AREA_W-1:0] area_i = 3'h0;
  logic              reg_wr_i = 1'b0;
  logic              reg_rd_i = 1'b0;
  logic              dma_wr_start_i = 1'b0;
  logic              mux_io_i = 1'b0;
  logic              bus16_i = 1'b1;
  logic              byte_hi_i = 1'b1;
  logic              byte_lo_i = 1'b1;
  logic              wait_n_i, cyc_busy_o, cyc_done_o, start_refused_o, wait_pin_pullup_o;
  logic              ras_n_o, upper_col_strobe_n_o, lower_col_strobe_n_o;
  logic              upper_write_strobe_n_o, lower_write_strobe_n_o;
  logic [3:0]        start_at = 4'h0;
  logic [3:0]        extra = 4'h0;
  logic [4:0]        strobes;
  logic              poke = 1'b0;
  int                n_mismatch = 0;
  int                compares = 0;
  ext_bus_wait_ctrl i_dut (
    .ref_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .dma_wr_start_i, .area_i, .mux_io_i, .bus16_i, .byte_hi_i, .byte_lo_i,
    .wait_n_i, .cyc_busy_o, .cyc_done_o, .start_refused_o, .wait_pin_pullup_o, .ras_n_o,
    .upper_col_strobe_n_o, .lower_col_strobe_n_o, .upper_write_strobe_n_o,
    .lower_write_strobe_n_o
  );
  ext_mem_model i_mem (
    .ref_clk_i, .busy_i(cyc_busy_o), .start_at_i(start_at), .extra_i(extra), .wait_n_o(wait_n_i)
  );
  initial begin
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] e);
    compares++;
    if (got !== e) begin
      n_mismatch++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, e);
  endtask
  // one dma write cycle; counts busy states and keeps the strobes of the first
  task automatic run_cyc(input logic [2:0] a, input int exp_len);
    int n;
    int i;
    n = 0;
    repeat (4) @(posedge ref_clk_i);
    area_i <= a;
    dma_wr_start_i <= 1'b1;
    @(posedge ref_clk_i);
    dma_wr_start_i <= 1'b0;
    for (i = 0; i < 40 && cyc_done_o !== 1'b1; i++) begin
      @(posedge ref_clk_i);
      dma_wr_start_i <= poke && n == 1;
      #1;
      if (poke && n == 2) chk({15'h0000, start_refused_o}, 16'h0001);
      if (cyc_busy_o === 1'b1 && n == 0) strobes = {ras_n_o, upper_col_strobe_n_o,
        lower_col_strobe_n_o, upper_write_strobe_n_o, lower_write_strobe_n_o};
      if (cyc_busy_o === 1'b1) n++;
    end
    if (cyc_done_o !== 1'b1) begin
      n_mismatch++;
      print_verdict();
    end else begin
      chk(16'(n), 16'(exp_len));
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd_chk(OFS_DMA_WW, 16'h00ff);
    rd_chk(OFS_WAIT_LW, 16'hf800);
    rd_chk(OFS_DRAM_AREA, 16'h0000);
    chk({15'h0000, wait_pin_pullup_o}, 16'h0001);
    chk(16'({ras_n_o, upper_col_strobe_n_o, lower_col_strobe_n_o}), 16'h0007);
    wr_reg(4'h2, 16'hffff);
    rd_chk(4'h2, 16'h0000);
    wr_reg(OFS_WAIT_LW, 16'h9800);
    rd_chk(OFS_WAIT_LW, 16'h9800);
    wr_reg(OFS_WAIT_LW, 16'h0000);
    rd_chk(OFS_WAIT_LW, 16'h0000);
    chk({15'h0000, wait_pin_pullup_o}, 16'h0000);
    wr_reg(OFS_WAIT_LW, 16'hf800);
    $display("test registers done");
  endtask
  task automatic t_areas();
    int s;
    for (int a = 0; a < 8; a++) begin
      for (int b = 0; b < 2; b++) begin
        s = (a == 0 || a == 2 || a == 6) ? 5 : b + 1;
        wr_reg(OFS_DMA_WW, b ? 16'h0001 << a : 16'h00ff ^ (16'h0001 << a));
        start_at = 4'(s - 1);
        extra = 4'h2;
        run_cyc(3'(a), s + 2 * b);
      end
    end
    wr_reg(OFS_DMA_WW, 16'h00ff);
    extra = 4'h0;
    for (int c = 0; c < 4; c++) begin
      wr_reg(OFS_WAIT_LW, {1'b1, 2'(c), 2'(3 - c), 11'h000});
      run_cyc(3'h2, c + 2);
      run_cyc(3'h6, 5 - c);
    end
    wr_reg(OFS_WAIT_LW, 16'hf800);
    $display("test area cycles done");
  endtask
  task automatic t_mux();
    mux_io_i <= 1'b1;
    wr_reg(OFS_DMA_WW, 16'h0000);
    start_at = 4'h3;
    extra = 4'h2;
    poke = 1'b1;
    run_cyc(3'h6, 6);
    poke = 1'b0;
    wr_reg(OFS_DMA_WW, 16'h00ff);
    run_cyc(3'h6, 6);
    mux_io_i <= 1'b0;
    $display("test multiplexed space done");
  endtask
  task automatic t_dram();
    int first [2];
    wr_reg(OFS_DMA_WW, 16'h00fd);
    start_at = 4'h0;
    run_cyc(3'h1, 1);
    chk(16'(strobes), 16'h001f);
    wr_reg(OFS_BUS_CTRL, 16'h0001);
    run_cyc(3'h1, 1);
    chk(16'(strobes), 16'h0002);
    @(posedge ref_clk_i);
    byte_hi_i <= 1'b0;
    run_cyc(3'h1, 1);
    chk(16'(strobes), 16'h000a);
    @(posedge ref_clk_i);
    byte_hi_i <= 1'b1;
    wr_reg(OFS_DMA_WW, 16'h00ff);
    wr_reg(OFS_DRAM_AREA, 16'h8000);
    start_at = 4'h1;
    run_cyc(3'h1, 4);
    chk(16'(strobes), 16'h0008);
    @(posedge ref_clk_i);
    byte_lo_i <= 1'b0;
    run_cyc(3'h1, 4);
    chk(16'(strobes), 16'h0009);
    @(posedge ref_clk_i);
    byte_lo_i <= 1'b1;
    bus16_i <= 1'b0;
    run_cyc(3'h1, 4);
    chk(16'(strobes), 16'h000a);
    @(posedge ref_clk_i);
    bus16_i <= 1'b1;
    for (int h = 1; h >= 0; h--) begin
      wr_reg(OFS_DRAM_AREA, h ? 16'h4000 : 16'h0000);
      run_cyc(3'h1, 4);
      repeat (3) @(posedge ref_clk_i);
      #1 chk({15'h0000, ras_n_o}, 16'(1 - h));
    end
    // earliest accepted gap after a cycle must grow by one with the long precharge
    for (int t = 0; t < 2; t++) begin
      wr_reg(OFS_DRAM_AREA, t ? 16'h2000 : 16'h0000);
      first[t] = 9;
      for (int d = 3; d >= 0; d--) begin
        run_cyc(3'h1, 4);
        repeat (d) @(posedge ref_clk_i);
        @(posedge ref_clk_i);
        dma_wr_start_i <= 1'b1;
        @(posedge ref_clk_i);
        dma_wr_start_i <= 1'b0;
        #1;
        if (start_refused_o === 1'b0) first[t] = d;
        for (int i = 0; i < 20 && first[t] == d && cyc_done_o !== 1'b1; i++) begin
          @(posedge ref_clk_i);
          #1;
        end
        if (first[t] == d && cyc_done_o !== 1'b1) begin
          n_mismatch++;
          print_verdict();
        end
      end
    end
    chk(16'(first[1]), 16'(first[0] + 1));
    $display("test dram signals done");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    t_regs();
    t_areas();
    t_mux();
    t_dram();
    print_verdict();
  end
endmodule // test_ext_bus_wait_ctrl
